// >>> ddc_pkg.sv
package ddc_pkg;
  localparam int SAMPLE_W = 12;
  localparam int IQ_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_OSC = 4;
  localparam int TW_W = 32;
  localparam int PHASE_W = 16;
  localparam int RDIV_W = 16;
  localparam int FIFO_DEPTH = 4;
  // converter-to-mixer and pin-to-mixer latencies, device clock cycles
  localparam int SAMPLE_DELAY = 36;
  localparam int SYNC_STAGES = 2;
  localparam int PIN_DELAY = 36;
  // register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] RDIV_OFF = 8'h04;
  localparam logic [7:0] STATUS_OFF = 8'h08;
  // word blocks, selected by address bits [7:4], word index by [3:2]
  localparam logic [3:0] BLK_MISC = 4'h0;
  localparam logic [3:0] BLK_TW_A = 4'h4;
  localparam logic [3:0] BLK_TW_B = 4'h5;
  localparam logic [3:0] BLK_PH_A = 4'h6;
  localparam logic [3:0] BLK_PH_B = 4'h7;
  // control register fields
  localparam int CTRL_DDC_EN = 0;
  localparam int CTRL_DUAL = 1;
  localparam int CTRL_SRC = 2;
  localparam int CTRL_SEL_A = 3;
  localparam int CTRL_SEL_B = 5;
  localparam int CTRL_ROUTE_B = 8;
  localparam int CTRL_ARM = 12;
  // status register fields
  localparam int STAT_SEL_A = 0;
  localparam int STAT_SEL_B = 2;
  localparam int STAT_ARMED = 4;
  localparam int STAT_FULL = 5;
  // chan_b_input_route encodings
  localparam logic [1:0] ROUTE_B_OWN = 2'h0;
  localparam logic [1:0] ROUTE_B_FROM_A = 2'h1;
  localparam logic [1:0] RDIV_BASIC = 2'h0;
  localparam logic [3:0] QUARTER_TURN = 4'h4;
  localparam logic [TW_W-1:0] TW_RESET = 32'h0000_0000;
  localparam logic [PHASE_W-1:0] PHASE_RESET = 16'h0000;
  localparam int PROD_MSB = 22;
  localparam int PROD_LSB = 7;

  typedef struct packed {
    logic bypass;
    logic [IQ_W-1:0] i_a;
    logic [IQ_W-1:0] q_a;
    logic [IQ_W-1:0] i_b;
    logic [IQ_W-1:0] q_b;
  } iq_sample_type;

  localparam int IQ_SAMPLE_W = $bits(iq_sample_type);
endpackage : ddc_pkg

// >>> sample_fifo.sv
`timescale 1ns/10ps
module sample_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic full_o
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W+1)'(DEPTH);
  localparam logic [PTR_W-1:0] LAST = (PTR_W)'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [PTR_W:0] count_q;
  logic push;
  logic pop;

  assign full_o = (count_q == DEPTH_CNT);
  assign in_ready_o = !full_o;
  assign out_valid_o = (count_q != '0);
  assign out_data_o = mem_q[rd_ptr_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == LAST) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == LAST) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  AST_FIFO_BOUNDS: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    count_q <= DEPTH_CNT) else $error("fifo count beyond depth");
endmodule : sample_fifo

// >>> ddc_nco_mixer_select.sv
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
// Operation
// [RULE1] samples bypass to output or go through mixing, mixing only in dual mode
// [RULE2] converter b has the same path, own source route and oscillator choice
// [RULE3] real sample times selected complex exponential shifts carrier by oscillator frequency
// [RULE4] each oscillator frequency comes from its own 32-bit tuning word register
// [RULE5] four oscillators per converter, each with own frequency and phase settings
// [RULE6] every phase accumulator advances each clock, selected or not
// [RULE7] hop pin changes switch oscillator, pins unaligned to samples
// [RULE8] hop pin change reaches mixer about 36 to 40 clocks later
// [RULE9] samples reach the mixer about 36 clocks after entry
// [RULE10] select_source high: hop pins pick oscillator as binary index
// [RULE11] select_source low, reset default: software field picks oscillator
// [RULE12] separate frequency and phase words per accumulator, divider stored alongside
// [RULE13] divider zero gives basic mode: frequency is word over 2^32 times clock
// [RULE14] 16-bit phase offset goes into upper half and adds to accumulator
// [RULE15] retuning leaves phase undetermined; software resynchronises when it matters
// [RULE16] armed sync resets all accumulators on next sysref rising edge
// [RULE17] hop pins pass a two-flop synchroniser before selection
// [RULE18] cosine and sine of selected phase give in-phase and quadrature products
module ddc_nco_mixer_select (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ddc_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [ddc_pkg::DATA_W-1:0] pwdata_i,
  output logic [ddc_pkg::DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [ddc_pkg::SAMPLE_W-1:0] sample_a_i,
  input wire logic [ddc_pkg::SAMPLE_W-1:0] sample_b_i,
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  input wire logic [1:0] hop_select_pins_a_i,
  input wire logic [1:0] hop_select_pins_b_i,
  input wire logic sysref_i,
  output ddc_pkg::iq_sample_type out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int SW = ddc_pkg::SAMPLE_W;
  localparam int SD = ddc_pkg::SAMPLE_DELAY;
  localparam int PD = ddc_pkg::PIN_DELAY;

  typedef struct packed {
    logic valid;
    logic [SW-1:0] a;
    logic [SW-1:0] b;
  } stage_type;

  logic ddc_enable_q;
  logic dual_mode_q;
  logic select_source_q;
  logic [1:0] sw_osc_select_a_q;
  logic [1:0] sw_osc_select_b_q;
  logic [1:0] chan_b_input_route_q;
  logic arm_sync_on_sysref_q;
  logic [ddc_pkg::RDIV_W-1:0] rational_divider_q;
  logic [ddc_pkg::TW_W-1:0] tuning_word_a_q [ddc_pkg::NUM_OSC];
  logic [ddc_pkg::TW_W-1:0] tuning_word_b_q [ddc_pkg::NUM_OSC];
  logic [ddc_pkg::PHASE_W-1:0] phase_offset_a_q [ddc_pkg::NUM_OSC];
  logic [ddc_pkg::PHASE_W-1:0] phase_offset_b_q [ddc_pkg::NUM_OSC];
  logic [ddc_pkg::TW_W-1:0] acc_a_q [ddc_pkg::NUM_OSC];
  logic [ddc_pkg::TW_W-1:0] acc_b_q [ddc_pkg::NUM_OSC];
  logic [1:0] hop_meta_a_q;
  logic [1:0] hop_meta_b_q;
  logic [1:0] hop_sync_a_q;
  logic [1:0] hop_sync_b_q;
  logic [1:0] hop_dly_a_q [PD];
  logic [1:0] hop_dly_b_q [PD];
  logic sysref_meta_q;
  logic sysref_sync_q;
  logic sysref_prev_q;
  logic sync_fire;
  stage_type pipe_q [SD];
  stage_type pipe_in;
  logic [ddc_pkg::DATA_W-1:0] prdata_q;
  logic [ddc_pkg::DATA_W-1:0] rdata_d;
  logic pslverr_q;
  logic err_d;
  logic apb_setup;
  logic apb_write;
  logic ctrl_write;
  logic [3:0] blk;
  logic [1:0] widx;
  logic [1:0] sel_a;
  logic [1:0] sel_b;
  logic [ddc_pkg::TW_W-1:0] phase_a;
  logic [ddc_pkg::TW_W-1:0] phase_b;
  logic signed [SW-1:0] cos_a;
  logic signed [SW-1:0] sin_a;
  logic signed [SW-1:0] cos_b;
  logic signed [SW-1:0] sin_b;
  logic signed [2*SW-1:0] prod_ia;
  logic signed [2*SW-1:0] prod_qa;
  logic signed [2*SW-1:0] prod_ib;
  logic signed [2*SW-1:0] prod_qb;
  logic ddc_active;
  logic fifo_in_ready;
  logic fifo_full;
  logic advance;
  ddc_pkg::iq_sample_type mix_out;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  // coarse 16-point sine; enough for mixing demo, spurs limit dynamic range
  localparam logic [SW-1:0] SINE_TAB [16] = '{12'h000, 12'h30f, 12'h5a7, 12'h763, 12'h7ff, 12'h763, 12'h5a7,
    12'h30f, 12'h000, 12'hcf1, 12'ha59, 12'h89d, 12'h801, 12'h89d, 12'ha59, 12'hcf1};

  function automatic logic signed [SW-1:0] sine_lut(input logic [3:0] ph);
    return $signed(SINE_TAB[ph]);
  endfunction : sine_lut

  // register bus: read data captured in setup, zero wait states
  assign apb_setup = psel_i && !penable_i;
  assign apb_write = psel_i && penable_i && pwrite_i && !pslverr_q;
  assign blk = paddr_i[7:4];
  assign widx = paddr_i[3:2];
  assign ctrl_write = apb_write && (paddr_i == ddc_pkg::CTRL_OFF);
  assign pready_o = 1'b1;
  assign prdata_o = prdata_q;
  assign pslverr_o = pslverr_q;

  always_comb begin
    rdata_d = '0;
    err_d = 1'b0;
    case (blk)
      ddc_pkg::BLK_MISC: begin
        if (paddr_i == ddc_pkg::CTRL_OFF) begin
          rdata_d[ddc_pkg::CTRL_DDC_EN] = ddc_enable_q;
          rdata_d[ddc_pkg::CTRL_DUAL] = dual_mode_q;
          rdata_d[ddc_pkg::CTRL_SRC] = select_source_q;
          rdata_d[ddc_pkg::CTRL_SEL_A +: 2] = sw_osc_select_a_q;
          rdata_d[ddc_pkg::CTRL_SEL_B +: 2] = sw_osc_select_b_q;
          rdata_d[ddc_pkg::CTRL_ROUTE_B +: 2] = chan_b_input_route_q;
          rdata_d[ddc_pkg::CTRL_ARM] = arm_sync_on_sysref_q;
        end else if (paddr_i == ddc_pkg::RDIV_OFF) begin
          rdata_d[ddc_pkg::RDIV_W-1:0] = rational_divider_q;
        end else if (paddr_i == ddc_pkg::STATUS_OFF) begin
          rdata_d[ddc_pkg::STAT_SEL_A +: 2] = sel_a;
          rdata_d[ddc_pkg::STAT_SEL_B +: 2] = sel_b;
          rdata_d[ddc_pkg::STAT_ARMED] = arm_sync_on_sysref_q;
          rdata_d[ddc_pkg::STAT_FULL] = fifo_full;
        end else begin
          err_d = 1'b1;
        end
      end
      ddc_pkg::BLK_TW_A: rdata_d = tuning_word_a_q[widx];
      ddc_pkg::BLK_TW_B: rdata_d = tuning_word_b_q[widx];
      ddc_pkg::BLK_PH_A: rdata_d[ddc_pkg::PHASE_W-1:0] = phase_offset_a_q[widx];
      ddc_pkg::BLK_PH_B: rdata_d[ddc_pkg::PHASE_W-1:0] = phase_offset_b_q[widx];
      default: err_d = 1'b1;
    endcase
    if (paddr_i[1:0] != 2'h0) begin
      err_d = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else if (apb_setup) begin
      prdata_q <= pwrite_i ? '0 : rdata_d;
      pslverr_q <= err_d;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ddc_enable_q <= 1'b0;
      dual_mode_q <= 1'b0;
      select_source_q <= 1'b0; // [RULE11]
      sw_osc_select_a_q <= 2'h0;
      sw_osc_select_b_q <= 2'h0;
      chan_b_input_route_q <= ddc_pkg::ROUTE_B_OWN;
      rational_divider_q <= '0;
    end else if (apb_write) begin
      if (paddr_i == ddc_pkg::CTRL_OFF) begin
        ddc_enable_q <= pwdata_i[ddc_pkg::CTRL_DDC_EN];
        dual_mode_q <= pwdata_i[ddc_pkg::CTRL_DUAL];
        select_source_q <= pwdata_i[ddc_pkg::CTRL_SRC];
        sw_osc_select_a_q <= pwdata_i[ddc_pkg::CTRL_SEL_A +: 2];
        sw_osc_select_b_q <= pwdata_i[ddc_pkg::CTRL_SEL_B +: 2];
        chan_b_input_route_q <= pwdata_i[ddc_pkg::CTRL_ROUTE_B +: 2];
      end
      if (paddr_i == ddc_pkg::RDIV_OFF) begin
        rational_divider_q <= pwdata_i[ddc_pkg::RDIV_W-1:0]; // [RULE12]
      end
    end
  end

  // per-oscillator frequency and phase words
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int k = 0; k < ddc_pkg::NUM_OSC; k++) begin
        tuning_word_a_q[k] <= ddc_pkg::TW_RESET;
        tuning_word_b_q[k] <= ddc_pkg::TW_RESET;
        phase_offset_a_q[k] <= ddc_pkg::PHASE_RESET;
        phase_offset_b_q[k] <= ddc_pkg::PHASE_RESET;
      end
    end else if (apb_write) begin
      case (blk)
        ddc_pkg::BLK_TW_A: tuning_word_a_q[widx] <= pwdata_i; // [RULE4] [RULE5]
        ddc_pkg::BLK_TW_B: tuning_word_b_q[widx] <= pwdata_i; // [RULE4] [RULE5]
        ddc_pkg::BLK_PH_A: phase_offset_a_q[widx] <= pwdata_i[ddc_pkg::PHASE_W-1:0]; // [RULE5] [RULE12]
        ddc_pkg::BLK_PH_B: phase_offset_b_q[widx] <= pwdata_i[ddc_pkg::PHASE_W-1:0]; // [RULE5] [RULE12]
        default: ;
      endcase
    end
  end

  // sysref edge and arming; a new arm in the firing cycle wins
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sysref_meta_q <= 1'b0;
      sysref_sync_q <= 1'b0;
      sysref_prev_q <= 1'b0;
    end else begin
      sysref_meta_q <= sysref_i;
      sysref_sync_q <= sysref_meta_q;
      sysref_prev_q <= sysref_sync_q;
    end
  end

  assign sync_fire = arm_sync_on_sysref_q && sysref_sync_q && !sysref_prev_q; // [RULE16]

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      arm_sync_on_sysref_q <= 1'b0;
    end else if (ctrl_write) begin
      arm_sync_on_sysref_q <= pwdata_i[ddc_pkg::CTRL_ARM] || (arm_sync_on_sysref_q && !sync_fire);
    end else if (sync_fire) begin
      arm_sync_on_sysref_q <= 1'b0;
    end
  end

  // accumulators never stall, so a hop back resumes with continuous phase;
  // retuning without resync leaves the phase where it happens to be
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int k = 0; k < ddc_pkg::NUM_OSC; k++) begin
        acc_a_q[k] <= '0;
        acc_b_q[k] <= '0;
      end
    end else begin
      for (int k = 0; k < ddc_pkg::NUM_OSC; k++) begin
        if (sync_fire) begin
          acc_a_q[k] <= '0; // [RULE16] [RULE15]
          acc_b_q[k] <= '0; // [RULE16]
        end else begin
          acc_a_q[k] <= acc_a_q[k] + tuning_word_a_q[k]; // [RULE6] [RULE13]
          acc_b_q[k] <= acc_b_q[k] + tuning_word_b_q[k]; // [RULE6] [RULE13]
        end
      end
    end
  end

  // hop pins: synchroniser, then a delay matching the sample path
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hop_meta_a_q <= 2'h0;
      hop_meta_b_q <= 2'h0;
      hop_sync_a_q <= 2'h0;
      hop_sync_b_q <= 2'h0;
      for (int k = 0; k < PD; k++) begin
        hop_dly_a_q[k] <= 2'h0;
        hop_dly_b_q[k] <= 2'h0;
      end
    end else begin
      hop_meta_a_q <= hop_select_pins_a_i; // [RULE17] [RULE7]
      hop_meta_b_q <= hop_select_pins_b_i;
      hop_sync_a_q <= hop_meta_a_q; // [RULE17]
      hop_sync_b_q <= hop_meta_b_q;
      hop_dly_a_q[0] <= hop_sync_a_q; // [RULE8]
      hop_dly_b_q[0] <= hop_sync_b_q;
      for (int k = 1; k < PD; k++) begin
        hop_dly_a_q[k] <= hop_dly_a_q[k-1]; // [RULE8]
        hop_dly_b_q[k] <= hop_dly_b_q[k-1];
      end
    end
  end

  assign sel_a = select_source_q ? hop_dly_a_q[PD-1] : sw_osc_select_a_q; // [RULE10] [RULE11]
  assign sel_b = select_source_q ? hop_dly_b_q[PD-1] : sw_osc_select_b_q; // [RULE2] [RULE10]

  // sample delay line; it stalls with the output fifo so nothing is dropped
  assign advance = fifo_in_ready;
  assign sample_ready_o = advance;
  assign pipe_in.valid = sample_valid_i;
  assign pipe_in.a = sample_a_i;
  assign pipe_in.b = (chan_b_input_route_q == ddc_pkg::ROUTE_B_FROM_A) ? sample_a_i : sample_b_i; // [RULE2]

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int k = 0; k < SD; k++) begin
        pipe_q[k] <= '0;
      end
    end else if (advance) begin
      pipe_q[0] <= pipe_in; // [RULE9]
      for (int k = 1; k < SD; k++) begin
        pipe_q[k] <= pipe_q[k-1]; // [RULE9]
      end
    end
  end

  // mixer
  assign ddc_active = ddc_enable_q && dual_mode_q; // [RULE1]
  assign phase_a = acc_a_q[sel_a] + {phase_offset_a_q[sel_a], ddc_pkg::PHASE_RESET}; // [RULE14]
  assign phase_b = acc_b_q[sel_b] + {phase_offset_b_q[sel_b], ddc_pkg::PHASE_RESET}; // [RULE14]
  assign sin_a = sine_lut(phase_a[31:28]); // [RULE18]
  assign cos_a = sine_lut(phase_a[31:28] + ddc_pkg::QUARTER_TURN); // [RULE18]
  assign sin_b = sine_lut(phase_b[31:28]);
  assign cos_b = sine_lut(phase_b[31:28] + ddc_pkg::QUARTER_TURN);
  assign prod_ia = $signed(pipe_q[SD-1].a) * cos_a; // [RULE3]
  assign prod_qa = $signed(pipe_q[SD-1].a) * sin_a; // [RULE3]
  assign prod_ib = $signed(pipe_q[SD-1].b) * cos_b; // [RULE2] [RULE3]
  assign prod_qb = $signed(pipe_q[SD-1].b) * sin_b;

  always_comb begin
    mix_out = '0;
    mix_out.bypass = !ddc_active;
    if (ddc_active) begin
      mix_out.i_a = prod_ia[ddc_pkg::PROD_MSB:ddc_pkg::PROD_LSB];
      mix_out.q_a = prod_qa[ddc_pkg::PROD_MSB:ddc_pkg::PROD_LSB];
      mix_out.i_b = prod_ib[ddc_pkg::PROD_MSB:ddc_pkg::PROD_LSB];
      mix_out.q_b = prod_qb[ddc_pkg::PROD_MSB:ddc_pkg::PROD_LSB];
    end else begin
      mix_out.i_a = {{(ddc_pkg::IQ_W-SW){pipe_q[SD-1].a[SW-1]}}, pipe_q[SD-1].a}; // [RULE1]
      mix_out.i_b = {{(ddc_pkg::IQ_W-SW){pipe_q[SD-1].b[SW-1]}}, pipe_q[SD-1].b};
    end
  end

  sample_fifo #(
    .WIDTH(ddc_pkg::IQ_SAMPLE_W),
    .DEPTH(ddc_pkg::FIFO_DEPTH)
  ) out_fifo (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .in_valid_i(pipe_q[SD-1].valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(mix_out),
    .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i),
    .out_data_o(out_data_o),
    .full_o(fifo_full)
  );

  AST_HOP_LATENCY: assert property ((select_source_q && $past(select_source_q)) |-> // [RULE8]
    sel_a == $past(hop_select_pins_a_i, 38)) else $error("hop pin not at mixer after 38 cycles");
  AST_SW_SELECT: assert property (!select_source_q |-> // [RULE11]
    (sel_a == sw_osc_select_a_q && sel_b == sw_osc_select_b_q)) else $error("software select ignored");
  AST_ACC_FREE_RUN: assert property ((sel_a != 2'h0 && !sync_fire) |=> // [RULE6]
    acc_a_q[0] == $past(acc_a_q[0]) + $past(tuning_word_a_q[0])) else $error("idle accumulator stalled");
  AST_SYNC_RESET: assert property (sync_fire |=> // [RULE16]
    (acc_a_q[0] == '0 && acc_a_q[3] == '0 && acc_b_q[2] == '0)) else $error("sync did not clear accumulators");
  AST_ARM_CLEAR: assert property ((sync_fire && !ctrl_write) |=> !arm_sync_on_sysref_q) // [RULE16]
    else $error("arm not cleared after firing");
  // follows one sample at a time down the delay line; later ones pass untracked
  localparam logic [5:0] LAT_END = 6'(SD);
  logic [5:0] lat_cnt_q;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lat_cnt_q <= '0;
    end else if (advance) begin
      if (lat_cnt_q == '0) begin
        lat_cnt_q <= {5'h00, sample_valid_i};
      end else begin
        lat_cnt_q <= (lat_cnt_q == LAT_END) ? '0 : lat_cnt_q + 1'b1;
      end
    end
  end
  AST_SAMPLE_LAT: assert property (lat_cnt_q == LAT_END |-> pipe_q[SD-1].valid) // [RULE9]
    else $error("sample not at mixer after 36 cycles");
  AST_BYPASS: assert property ((!dual_mode_q && pipe_q[SD-1].valid) |-> // [RULE1]
    (mix_out.bypass && mix_out.q_a == '0 && mix_out.i_a[SW-1:0] == pipe_q[SD-1].a)) else $error("bypass wrong");
  AST_ROUTE_B: assert property ((chan_b_input_route_q == ddc_pkg::ROUTE_B_FROM_A && advance) |=> // [RULE2]
    pipe_q[0].b == pipe_q[0].a) else $error("channel b route wrong");
  AST_PHASE_OFFSET: assert property (!select_source_q |-> // [RULE14]
    (phase_a[31:16] == acc_a_q[sw_osc_select_a_q][31:16] + phase_offset_a_q[sw_osc_select_a_q] &&
    phase_a[15:0] == acc_a_q[sw_osc_select_a_q][15:0])) else $error("phase offset not in upper half");
  AST_APB_ERR: assert property ((apb_setup && paddr_i[7:4] == 4'hf) |=> pslverr_o) // [RULE12]
    else $error("unmapped access not flagged");

  COV_HOP: cover property (select_source_q && $changed(sel_a));
  COV_SYNC: cover property (sync_fire);
  COV_STALL: cover property (fifo_full && sample_valid_i);
  COV_MIX_OUT: cover property (ddc_active && out_valid_o && out_ready_i);
endmodule : ddc_nco_mixer_select

// >>> conv_stream_model.sv
`timescale 1ns/10ps
module conv_stream_model (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic run_i,
  input wire logic stall_i,
  input wire logic [ddc_pkg::SAMPLE_W-1:0] value_a_i,
  input wire logic [ddc_pkg::SAMPLE_W-1:0] value_b_i,
  output logic [ddc_pkg::SAMPLE_W-1:0] sample_a_o,
  output logic [ddc_pkg::SAMPLE_W-1:0] sample_b_o,
  output logic sample_valid_o,
  input wire logic sample_ready_i,
  input wire ddc_pkg::iq_sample_type out_data_i,
  input wire logic out_valid_i,
  output logic out_ready_o,
  output logic [15:0] sent_o,
  output logic [15:0] got_o,
  output ddc_pkg::iq_sample_type last_o
);
  // idle lines show the inverse, never a stale copy that could pass by luck
  assign sample_a_o = sample_valid_o ? value_a_i : ~value_a_i;
  assign sample_b_o = sample_valid_o ? value_b_i : ~value_b_i;
  assign out_ready_o = !stall_i;
  // a sample stays offered until taken
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sample_valid_o <= 1'b0;
      sent_o <= 16'h0000;
    end else begin
      if (!sample_valid_o || sample_ready_i) begin
        sample_valid_o <= run_i;
      end
      if (sample_valid_o && sample_ready_i) begin
        sent_o <= sent_o + 16'h0001;
      end
    end
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      got_o <= 16'h0000;
      last_o <= '0;
    end else if (out_valid_i && out_ready_o) begin
      got_o <= got_o + 16'h0001;
      last_o <= out_data_i;
    end
  end
endmodule : conv_stream_model

// >>> ddc_nco_mixer_select_tb_top.sv
`timescale 1ns/10ps
module ddc_nco_mixer_select_tb_top;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0, stall = 1'b0, sysref = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, svalid, sready, ovalid, oready;
  logic [1:0] pins_a = 2'h0, pins_b = 2'h0;
  logic [11:0] sa, sb;
  logic [15:0] sent, got, s0, g0;
  ddc_pkg::iq_sample_type odata, last;
  int err_total = 0, num_checks = 0, cyc = 0, n;

  always #25 clock_i = ~clock_i;

  ddc_nco_mixer_select dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .sample_a_i(sa), .sample_b_i(sb), .sample_valid_i(svalid),
    .sample_ready_o(sready), .hop_select_pins_a_i(pins_a), .hop_select_pins_b_i(pins_b),
    .sysref_i(sysref), .out_data_o(odata), .out_valid_o(ovalid), .out_ready_i(oready));
  conv_stream_model far (.clock_i(clock_i), .arst_n_i(arst_n_i), .run_i(run), .stall_i(stall),
    .value_a_i(12'h064), .value_b_i(12'h032), .sample_a_o(sa), .sample_b_o(sb), .sample_valid_o(svalid),
    .sample_ready_i(sready), .out_data_i(odata), .out_valid_i(ovalid), .out_ready_o(oready),
    .sent_o(sent), .got_o(got), .last_o(last));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do begin
      @(posedge clock_i);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rd_chk

  // n counts edges from offering one sample to its result leaving
  task one_sample;
    logic [15:0] g;
    g = got;
    run <= 1'b1;
    @(posedge clock_i);
    run <= 1'b0;
    n = 0;
    while (got == g && n < 100) begin
      @(posedge clock_i);
      n++;
    end
  endtask : one_sample

  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  initial begin
    repeat (10) @(posedge clock_i);
    arst_n_i <= 1'b1;
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h08, 32'h0);
    xfer(1'b0, 8'h0c, 32'h0);
    check(er, 1'b1);
    xfer(1'b1, 8'hf0, 32'h0);
    check(er, 1'b1);
    xfer(1'b1, 8'h48, 32'hdead_beef);
    rd_chk(8'h48, 32'hdead_beef);
    xfer(1'b1, 8'h7c, 32'hffff_1234);
    rd_chk(8'h7c, 32'h0000_1234);
    xfer(1'b1, 8'h04, 32'h0000_0780);
    rd_chk(8'h04, 32'h0000_0780);
    xfer(1'b1, 8'h48, 32'h0);
    xfer(1'b1, 8'h04, 32'h0);
    $display("test registers done");
    one_sample();
    check(n >= 37 && n <= 41, 1'b1);
    check({last.i_a, last.q_a}, {16'h0064, 16'h0});
    check({31'h0, last.bypass}, 32'h1);
    check({last.i_b, last.q_b}, {16'h0032, 16'h0});
    $display("test bypass done");
    // pin control, software fields set to 3 must be ignored
    xfer(1'b1, 8'h00, 32'h0000_007c);
    rd_chk(8'h08, 32'h0);
    pins_a <= 2'h1;
    pins_b <= 2'h2;
    repeat (30) @(posedge clock_i);
    rd_chk(8'h08, 32'h0);
    repeat (10) @(posedge clock_i);
    rd_chk(8'h08, 32'h9);
    $display("test hop pins done");
    // quarter-turn offset on oscillator 1 of a swaps cosine and sine
    xfer(1'b1, 8'h64, 32'h0000_4000);
    xfer(1'b1, 8'h00, 32'h0000_000b);
    rd_chk(8'h08, 32'h1);
    one_sample();
    check({last.i_a, last.q_a}, {16'd0, 16'd1599});
    check({31'h0, last.bypass}, 32'h0);
    check({last.i_b, last.q_b}, {16'd799, 16'd0});
    $display("test mixer done");
    s0 = sent;
    g0 = got;
    stall <= 1'b1;
    run <= 1'b1;
    n = 0;
    while (sready !== 1'b0 && n < 400) begin
      @(posedge clock_i);
      n++;
    end
    check(sready, 1'b0);
    rd_chk(8'h08, 32'h21);
    run <= 1'b0;
    stall <= 1'b0;
    repeat (150) @(posedge clock_i);
    check({16'h0, got - g0}, {16'h0, sent - s0});
    $display("test fifo done");
    // channel b takes channel a samples
    xfer(1'b1, 8'h00, 32'h0000_010b);
    one_sample();
    check({last.i_b, last.q_b}, {16'd1599, 16'd0});
    $display("test route done");
    // retuned, so phase is resynchronised on sysref
    xfer(1'b1, 8'h40, 32'h1000_0000);
    xfer(1'b1, 8'h00, 32'h0000_100b);
    rd_chk(8'h08, 32'h11);
    sysref <= 1'b1;
    repeat (5) @(posedge clock_i);
    sysref <= 1'b0;
    rd_chk(8'h08, 32'h1);
    rd_chk(8'h00, 32'h0000_000b);
    $display("test sync done");
    give_verdict();
  end
endmodule : ddc_nco_mixer_select_tb_top
